/* File: design/adsc_defines.vh */
// constants for the converter sequence controller
`ifndef ADSC_DEFINES_VH
`define ADSC_DEFINES_VH

// ***********************************************
// register word indexes (byte address = 4 * index)
// ***********************************************
`define ADSC_IDX_PWR      6'h00
`define ADSC_IDX_FRZ      6'h01
`define ADSC_IDX_TIM      6'h02
`define ADSC_IDX_MODE     6'h03
`define ADSC_IDX_STAT     6'h04
`define ADSC_RES_BLK      3'h1

// ***********************************************
// power / irq control field positions
// ***********************************************
`define ADSC_PWR_UP       7
`define ADSC_PWR_FFC      6
`define ADSC_PWR_WAI      5
`define ADSC_PWR_IEN      1
`define ADSC_PWR_IFLG     0

// ***********************************************
// mode / channel field positions
// ***********************************************
`define ADSC_MODE_S8      6
`define ADSC_MODE_SCAN    5
`define ADSC_MODE_MULTI_CHANNEL_SELECT    4

// ***********************************************
// status field positions
// ***********************************************
`define ADSC_STAT_SCF     7

// ***********************************************
// reset values
// ***********************************************
`define ADSC_RST_PWR      8'h00
`define ADSC_RST_FRZ      2'h0
`define ADSC_RST_TIM      7'h01
`define ADSC_RST_MODE     7'h00

// ***********************************************
// conversion phase lengths in converter clocks
// ***********************************************
`define ADSC_T_INIT       5'h02
`define ADSC_T_XFER       5'h04
`define ADSC_T_RES        5'h0a

// ***********************************************
// freeze codes
// ***********************************************
`define ADSC_FRZ_RUN      2'h0
`define ADSC_FRZ_END      2'h2
`define ADSC_FRZ_NOW      2'h3

`endif

/* File: design/adsc_top.v */
// converter sequence controller with avalon-mm register slave
//
// Contract
// [RULE_01] eight-conversion bit 1 gives eight conversions per sequence, 0 gives four
// [RULE_02] single mode sets sequence complete flag after last conversion, then stops
// [RULE_03] scan bit 1 restarts sequences forever after first complete; 0 runs one
// [RULE_04] conversion complete flag n sets when result register n is loaded
// [RULE_05] no fast clear: status read then result read clears that flag
// [RULE_06] fast clear: any access to result register clears its flag
// [RULE_07] control write during conversion aborts; idle until mode register written
// [RULE_08] mode register write starts sequence, aborts old one, clears flags
// [RULE_09] power-up bit 1 runs converter clock and analog; 0 disables converter
// [RULE_10] software waits for analog settling after power-up before trusting results
// [RULE_11] wait-stop bit 1 disables converter in wait mode; 0 keeps it running
// [RULE_12] sequence irq flag sets at sequence end; irq while flag and enable
// [RULE_13] power/irq register read/write anytime; its irq flag is read-only
// [RULE_14] freeze 00 runs, 10 finishes conversion then freezes, 11 freezes now
// [RULE_15] conversion: 2 initial, 4 transfer, final sample, 10 resolution clocks
// [RULE_16] sample code 00/01/10/11 gives final sample of 2/4/8/16 clocks
// [RULE_17] converter clock is periph clock over divider plus one, then halved
// [RULE_18] divider field resets to 00001, total divisor four
// [RULE_19] multichannel 1 steps channels; 0 uses the four-bit channel field
// [RULE_20] n-th conversion result goes to result register n with flag n
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`include "adsc_defines.vh"

module adsc_top (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire [7:0]  address_i,
  input  wire        read_i,
  input  wire        write_i,
  input  wire [31:0] writedata_i,
  output reg  [31:0] readdata_o,
  output reg         waitrequest_o,
  input  wire        wait_mode_i,
  input  wire        debug_halt_i,
  input  wire [7:0]  result_i,
  output reg         analog_en_o,
  output reg         conv_clk_o,
  output reg  [3:0]  channel_o,
  output reg         sample_o,
  output reg         resolve_o,
  output reg         irq_o
);

  // ***********************************************
  // state codes
  // ***********************************************
  // one-hot, one bit per phase
  localparam ST_IDLE = 3'b001;
  localparam ST_SMP  = 3'b010;
  localparam ST_RES  = 3'b100;

  // ***********************************************
  // declarations
  // ***********************************************
  reg  [7:0] pwr;
  reg  [1:0] frz;
  reg  [6:0] tim;
  reg  [6:0] mode;
  reg        sequence_complete_flag;
  reg  [7:0] ccf;
  reg        stat_armed;
  reg  [7:0] res_mem [0:7];
  reg  [7:0] res_s1;
  reg  [7:0] res_s2;
  reg  [4:0] pre_cnt;
  reg  [2:0] state;
  reg  [4:0] cnt;
  reg  [2:0] idx;
  reg  [31:0] next_rdata;
  wire       acc;
  wire       wr;
  wire [5:0] wsel;
  wire       res_hit;
  wire       wr_mode;
  wire       wr_other;
  wire       run;
  wire       pre_tick;
  wire       tick;
  wire       frz_now;
  wire       frz_end;
  wire       hold;
  wire       step;
  wire [4:0] fin_smp;
  wire [4:0] smp_len;
  wire       smp_done;
  wire       res_done;
  wire [2:0] last_idx;
  wire       ld;
  wire       seq_end;

  // ***********************************************
  // bus decode
  // ***********************************************
  // accepted access and word decode of the byte address
  assign acc      = (read_i | write_i) & ~waitrequest_o;
  assign wr       = write_i & ~waitrequest_o;
  assign wsel     = address_i[7:2];
  assign res_hit  = (wsel[5:3] == `ADSC_RES_BLK);
  assign wr_mode  = wr & (wsel == `ADSC_IDX_MODE);
  assign wr_other = wr & ((wsel == `ADSC_IDX_PWR) | (wsel == `ADSC_IDX_FRZ) |
                          (wsel == `ADSC_IDX_TIM));

  // one wait cycle, then acknowledge
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      waitrequest_o <= 1'b1;
    end else if (acc) begin
      waitrequest_o <= 1'b1;
    end else if (read_i | write_i) begin
      waitrequest_o <= 1'b0;
    end
  end

  // read mux, unmapped reads zero
  always @* begin
    next_rdata = 32'h0000_0000;
    if (res_hit) begin
      next_rdata[7:0] = res_mem[wsel[2:0]];
    end else begin
      case (wsel)
        `ADSC_IDX_PWR:  next_rdata[7:0]  = pwr; // [RULE_13]
        `ADSC_IDX_FRZ:  next_rdata[1:0]  = frz;
        `ADSC_IDX_TIM:  next_rdata[6:0]  = tim;
        `ADSC_IDX_MODE: next_rdata[6:0]  = mode;
        `ADSC_IDX_STAT: next_rdata[15:0] = {ccf, sequence_complete_flag, 4'h0, idx};
        default:        next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // read data captured during the wait cycle
  // so it stands in the acknowledge cycle
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i & waitrequest_o) begin
      readdata_o <= next_rdata;
    end
  end

  // ***********************************************
  // control registers
  // ***********************************************
  // writable controls; the irq flag bit is set by hardware only
  // and a write to the power register leaves it untouched
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr  <= `ADSC_RST_PWR;
      frz  <= `ADSC_RST_FRZ;
      tim  <= `ADSC_RST_TIM; // [RULE_18]
      mode <= `ADSC_RST_MODE;
    end else begin
      if (wr & (wsel == `ADSC_IDX_PWR)) begin
        pwr[7:1] <= {writedata_i[7:5], 3'h0, writedata_i[1]}; // [RULE_13]
      end
      if (seq_end) begin
        pwr[`ADSC_PWR_IFLG] <= 1'b1; // [RULE_12]
      end else if (wr_mode) begin
        pwr[`ADSC_PWR_IFLG] <= 1'b0;
      end
      if (wr & (wsel == `ADSC_IDX_FRZ)) begin
        frz <= writedata_i[1:0];
      end
      if (wr & (wsel == `ADSC_IDX_TIM)) begin
        tim <= writedata_i[6:0];
      end
      if (wr_mode) begin
        mode <= writedata_i[6:0];
      end
    end
  end

  // interrupt request from flag and enable
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= pwr[`ADSC_PWR_IFLG] & pwr[`ADSC_PWR_IEN]; // [RULE_12]
    end
  end

  // ***********************************************
  // converter clock prescaler
  // ***********************************************
  // run gate and prescaler wrap; the wrap compares from above so a divider
  // lowered mid-count wraps at once instead of counting through 31
  assign run      = pwr[`ADSC_PWR_UP] & ~(wait_mode_i & pwr[`ADSC_PWR_WAI]); // [RULE_09] [RULE_11]
  assign pre_tick = (pre_cnt >= tim[4:0]);
  assign tick     = run & pre_tick & conv_clk_o; // [RULE_17]

  // divide by value plus one, then symmetric halving
  // a stopped clock parks low, so the analog side sees no stray edge
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_cnt    <= 5'h00;
      conv_clk_o <= 1'b0;
    end else if (!run) begin
      pre_cnt    <= 5'h00;
      conv_clk_o <= 1'b0; // [RULE_09]
    end else if (pre_tick) begin
      pre_cnt    <= 5'h00;
      conv_clk_o <= ~conv_clk_o; // [RULE_17]
    end else begin
      pre_cnt    <= pre_cnt + 5'h01;
    end
  end

  // analog enable
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      analog_en_o <= 1'b0;
    end else begin
      analog_en_o <= run; // [RULE_09] [RULE_11]
    end
  end

  // ***********************************************
  // sequencer
  // ***********************************************
  // freeze: code 11 stops ticks at once, code 10 only at a conversion start
  // code 01 behaves as run
  assign frz_now  = debug_halt_i & (frz == `ADSC_FRZ_NOW); // [RULE_14]
  assign frz_end  = debug_halt_i & (frz == `ADSC_FRZ_END) &
                    state[1] & (cnt == 5'h00); // [RULE_14]
  assign hold     = frz_now | frz_end;
  assign step     = tick & ~hold;
  assign fin_smp  = 5'h02 << tim[6:5]; // [RULE_16]
  assign smp_len  = `ADSC_T_INIT + `ADSC_T_XFER + fin_smp; // [RULE_15]
  assign smp_done = state[1] & step & (cnt == smp_len - 5'h01);
  assign res_done = state[2] & step & (cnt == `ADSC_T_RES - 5'h01); // [RULE_15]
  assign last_idx = mode[`ADSC_MODE_S8] ? 3'h7 : 3'h3; // [RULE_01]
  // a control write in the load cycle wins: no result store, no flags
  assign ld       = res_done & ~wr_mode & ~wr_other;
  assign seq_end  = ld & (idx == last_idx);

  // phase, tick counter and conversion index
  // a mode write restarts from slot zero, a control write parks the machine
  // the load of the last slot decides between stop and restart
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
      cnt   <= 5'h00;
      idx   <= 3'h0;
    end else if (wr_mode) begin
      state <= ST_SMP; // [RULE_08]
      cnt   <= 5'h00;
      idx   <= 3'h0;
    end else if (wr_other) begin
      state <= ST_IDLE; // [RULE_07]
      cnt   <= 5'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= 5'h00;
        end
        ST_SMP: begin
          if (smp_done) begin
            state <= ST_RES;
            cnt   <= 5'h00;
          end else if (step) begin
            cnt <= cnt + 5'h01;
          end
        end
        ST_RES: begin
          if (res_done) begin
            cnt <= 5'h00;
            if (idx != last_idx) begin
              state <= ST_SMP;
              idx   <= idx + 3'h1;
            end else if (mode[`ADSC_MODE_SCAN]) begin
              state <= ST_SMP; // [RULE_03]
              idx   <= 3'h0;
            end else begin
              state <= ST_IDLE; // [RULE_02]
            end
          end else if (step) begin
            cnt <= cnt + 5'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
          cnt   <= 5'h00;
        end
      endcase
    end
  end

  // phase strobes and channel to the analog side
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sample_o  <= 1'b0;
      resolve_o <= 1'b0;
      channel_o <= 4'h0;
    end else begin
      sample_o  <= state[1] & ~wr_mode & ~wr_other;
      resolve_o <= state[2] & ~wr_mode & ~wr_other;
      if (!mode[`ADSC_MODE_MULTI_CHANNEL_SELECT]) begin
        channel_o <= mode[3:0]; // [RULE_19]
      end else if (mode[`ADSC_MODE_S8]) begin
        channel_o <= {mode[3], idx}; // [RULE_19]
      end else begin
        channel_o <= {mode[3:2], idx[1:0]}; // [RULE_19]
      end
    end
  end

  // result pins from the analog side, two-stage synchroniser
  // the code is held steady through resolution, so all bits settle together
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      res_s1 <= 8'h00;
      res_s2 <= 8'h00;
    end else begin
      res_s1 <= result_i;
      res_s2 <= res_s1;
    end
  end

  // result store, no reset on data
  // a slot keeps its value until its next load
  always @(posedge clk_i) begin
    if (ld) begin
      res_mem[idx] <= res_s2; // [RULE_20]
    end
  end

  // ***********************************************
  // completion flags
  // ***********************************************
  // sequence complete, set by the final load, cleared by a mode write
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sequence_complete_flag <= 1'b0;
    end else if (seq_end) begin
      sequence_complete_flag <= 1'b1; // [RULE_02] [RULE_03]
    end else if (wr_mode) begin
      sequence_complete_flag <= 1'b0; // [RULE_08]
    end
  end

  // status read arms the slow flag clear
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_armed <= 1'b0;
    end else if (read_i & acc & (wsel == `ADSC_IDX_STAT)) begin
      stat_armed <= 1'b1;
    end else if (read_i & acc & res_hit) begin
      stat_armed <= 1'b0;
    end
  end

  // per-result flag, set wins over clear
  // slow clear needs an armed status read, fast clear takes any access
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ccf
      localparam [2:0] SLOT = g; // slot number at index width
      wire hit = acc & res_hit & (wsel[2:0] == SLOT);
      wire clr = hit & (pwr[`ADSC_PWR_FFC] | (read_i & stat_armed)); // [RULE_05] [RULE_06]
      always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          ccf[g] <= 1'b0;
        end else if (ld & (idx == SLOT)) begin
          ccf[g] <= 1'b1; // [RULE_04] [RULE_20]
        end else if (clr | wr_mode) begin
          ccf[g] <= 1'b0; // [RULE_08]
        end
      end
    end
  endgenerate

endmodule // adsc_top

/* File: dv/adsc_analog_model.sv */
// behavioural analog front end for the converter controller
module adsc_analog_model (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire        analog_en_i,
  input  wire [3:0]  channel_i,
  input  wire        sample_i,
  input  wire        resolve_i,
  output logic [7:0] result_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // code of sampled channel, held through resolution, scrambled otherwise
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_o <= 8'h00;
    end else if (analog_en_i && sample_i) begin
      result_o <= {4'h5, channel_i};
    end else if (!analog_en_i || !resolve_i) begin
      result_o <= ~result_o; // no valid result outside a conversion
    end
  end
endmodule // adsc_analog_model

/* File: dv/adsc_top_chk.sv */
// assertion checker for the converter sequence controller
module adsc_top_chk (
  input wire        clk_i,
  input wire        resetn_i,
  input wire [7:0]  address_i,
  input wire        read_i,
  input wire        write_i,
  input wire [31:0] writedata_i,
  input wire [31:0] readdata_o,
  input wire        waitrequest_o,
  input wire        wait_mode_i,
  input wire        debug_halt_i,
  input wire [7:0]  result_i,
  input wire        analog_en_o,
  input wire        conv_clk_o,
  input wire [3:0]  channel_o,
  input wire        sample_o,
  input wire        resolve_o,
  input wire        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // shadow state
  // ****
  logic [7:0] pwr_q;
  logic [7:0] tim_q;
  logic [9:0] res_cnt;
  logic       clean;
  wire        wr_ok   = write_i && !waitrequest_o;
  wire        mode_wr = wr_ok && address_i[7:2] == 6'h03;
  wire        ctl_wr  = wr_ok && address_i[7:2] < 6'h03;
  // copy of written controls, resolve length, undisturbed marker
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_q   <= 8'h00;
      tim_q   <= 8'h01;
      res_cnt <= 10'h000;
      clean   <= 1'b0;
    end else begin
      if (wr_ok && address_i[7:2] == 6'h00) pwr_q <= writedata_i[7:0];
      if (wr_ok && address_i[7:2] == 6'h02) tim_q <= writedata_i[7:0];
      res_cnt <= resolve_o ? res_cnt + 10'h001 : 10'h000;
      clean   <= (write_i || wait_mode_i || debug_halt_i) ? 1'b0 : (clean || !resolve_o);
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // ****
  // properties
  // ****
  AST_ACK_ONE: assert property ((read_i || write_i) && waitrequest_o
    |=> !waitrequest_o ##1 waitrequest_o)
    else $error("access not answered in one wait cycle");
  AST_OFF_NO_CLK: assert property ((!pwr_q[7]) [*3] |-> !analog_en_o && !conv_clk_o)
    else $error("converter active while powered down");
  AST_WAIT_STOP: assert property ((pwr_q[5] && wait_mode_i) [*3] |-> !conv_clk_o)
    else $error("converter clock runs in wait mode");
  AST_IRQ_GATE: assert property ((!pwr_q[1]) [*2] |-> !irq_o)
    else $error("irq without enable");
  AST_MODE_CLR: assert property (mode_wr |-> ##2 !irq_o)
    else $error("mode write left irq set");
  AST_MODE_START: assert property (mode_wr && pwr_q[7] && !wait_mode_i
    && !debug_halt_i |-> ##[1:3] sample_o)
    else $error("mode write did not start sampling");
  AST_ABORT: assert property (ctl_wr |-> ##2 (!sample_o && !resolve_o) [*2])
    else $error("control write did not abort");
  AST_RES_LEN: assert property ($fell(resolve_o) && clean
    |-> res_cnt == 20 * (tim_q[4:0] + 1))
    else $error("resolution phase length wrong");
endmodule // adsc_top_chk

bind adsc_top adsc_top_chk u_chk (.clk_i, .resetn_i, .address_i, .read_i, .write_i,
  .writedata_i, .readdata_o, .waitrequest_o, .wait_mode_i, .debug_halt_i, .result_i,
  .analog_en_o, .conv_clk_o, .channel_o, .sample_o, .resolve_o, .irq_o);

/* File: dv/test_adsc_top.sv */
// self-checking testbench for the converter sequence controller
module test_adsc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, resetn_i, read_i, write_i, wait_mode_i, debug_halt_i, h;
  logic [7:0]  address_i;
  logic [31:0] writedata_i, d;
  wire  [31:0] readdata_o;
  wire         waitrequest_o, analog_en_o, conv_clk_o, sample_o, resolve_o, irq_o;
  wire  [7:0]  result_i;
  wire  [3:0]  channel_o;
  int          err_count, checked, cyc, t1, t2;
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
  logic [7:0]  md [3] = '{8'h1c, 8'h5c, 8'h45};
  logic [7:0]  ms [3] = '{8'h0f, 8'hff, 8'hff};
  logic [3:0]  cb [3] = '{4'hc, 4'h8, 4'h5};
  logic [31:0] pw [6] = '{32'h80, 32'ha0, 32'h80, 32'h80, 32'h80, 32'h00};
  logic [31:0] fz [6] = '{32'h0, 32'h0, 32'h0, 32'h2, 32'h3, 32'h0};
  logic [31:0] ex [6] = '{32'hf80, 32'h0, 32'hf80, 32'h100, 32'h0, 32'h0};
  logic        wm [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  adsc_top uut (.clk_i, .resetn_i, .address_i, .read_i, .write_i, .writedata_i, .readdata_o,
    .waitrequest_o, .wait_mode_i, .debug_halt_i, .result_i, .analog_en_o, .conv_clk_o,
    .channel_o, .sample_o, .resolve_o, .irq_o);
  adsc_analog_model u_ana (.clk_i, .resetn_i, .analog_en_i(analog_en_o), .channel_i(channel_o),
    .sample_i(sample_o), .resolve_i(resolve_o), .result_o(result_i));

  // ****
  // clock, cycle count, tasks
  // ****
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    address_i   <= a;
    writedata_i <= wd;
    read_i      <= !w;
    write_i     <= w;
    do begin
      @(posedge clk_i);
    end while (waitrequest_o !== 1'b0);
    d = readdata_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
  endtask
  // cycle of next falling edge of the resolve phase
  task automatic fall(output int t);
    while (resolve_o !== 1'b1) @(posedge clk_i);
    while (resolve_o !== 1'b0) @(posedge clk_i);
    t = cyc;
  endtask
  // poll status until the sequence complete flag shows
  task automatic wait_scf;
    d = 0;
    while (d[7] !== 1'b1) bus(0, 8'h10, 0);
  endtask
  // any conversion activity over n cycles
  task automatic watch(input int n);
    h = 0;
    repeat (n) begin
      @(posedge clk_i);
      h = h | sample_o | resolve_o;
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****
  // watchdog and main sequence
  // ****
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    stop_test;
  end
  initial begin
    {clk_i, resetn_i, read_i, write_i, wait_mode_i, debug_halt_i} = 6'h00;
    address_i = 8'h00;
    writedata_i = 32'h0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(0, 8'(4 * i), 0);
      chk(d, rv[i]);
    end
    bus(1, 8'h00, 32'he3);
    bus(0, 8'h00, 0);
    chk(d, 32'he2);
    bus(1, 8'h00, 32'h80);
    repeat (50) @(posedge clk_i);
    for (int s = 0; s < 4; s++) begin
      bus(1, 8'h08, 32'((s << 5) | s));
      bus(1, 8'h0c, 0);
      fall(t1);
      fall(t2);
      chk(32'(t2 - t1), 32'((16 + (2 << s)) * 2 * (s + 1)));
    end
    bus(1, 8'h08, 32'h1);
    for (int i = 0; i < 3; i++) begin
      bus(1, 8'h00, 32'h82);
      bus(1, 8'h0c, {24'h0, md[i]});
      wait_scf;
      chk(d & 32'hff80, {16'h0, ms[i], 8'h80});
      chk(32'(irq_o), 32'h1);
      for (int n = 0; n < 8; n++) begin
        if (ms[i][n]) begin
          bus(0, 8'(32 + 4 * n), 0);
          chk(d, {24'h0, 4'h5, 4'(cb[i] + n * (i < 2))});
        end
      end
      bus(0, 8'h10, 0);
      chk(32'(d[15:8]), {24'h0, ms[i] & 8'hfe});
      chk(32'(sample_o), 32'h0);
    end
    bus(1, 8'h00, 32'hc0);
    bus(1, 8'h0c, 0);
    wait_scf;
    bus(1, 8'h28, 0);
    bus(0, 8'h10, 0);
    chk(32'(d[15:8]), 32'h0b);
    bus(1, 8'h00, 32'h80);
    bus(1, 8'h0c, 32'h20);
    wait_scf;
    watch(150);
    chk(32'(h), 32'h1);
    bus(1, 8'h0c, 32'h20);
    bus(0, 8'h10, 0);
    chk(d & 32'hff80, 32'h0);
    bus(1, 8'h04, 0);
    watch(3);
    watch(300);
    chk(32'(h), 32'h0);
    for (int i = 0; i < 6; i++) begin
      bus(1, 8'h00, pw[i]);
      bus(1, 8'h04, fz[i]);
      wait_mode_i  <= wm[i];
      bus(1, 8'h0c, 0);
      repeat (10) @(posedge clk_i);
      debug_halt_i <= (i > 1 && i < 5); // halt once conversion 0 is under way
      repeat (390) @(posedge clk_i);
      bus(0, 8'h10, 0);
      chk(d & 32'hff80, ex[i]);
      wait_mode_i  <= 1'b0;
      debug_halt_i <= 1'b0;
    end
    stop_test;
  end
endmodule // test_adsc_top
